/* hw/general_purpose_timer_set_regs.vh */
`ifndef GENERAL_PURPOSE_TIMER_SET_REGS_VH
`define GENERAL_PURPOSE_TIMER_SET_REGS_VH

// ----------------------------------------
// Address map (byte addresses, one word each)
// ----------------------------------------
// Timer n (0 = basic, 1..4 = pairable) sits at n * 0x10
`define TIMER_COUNT_OF 5
`define ADDR_TIMER_FIELD_HI 6
`define ADDR_TIMER_FIELD_LO 4
`define ADDR_REG_FIELD_HI 3
`define ADDR_REG_FIELD_LO 2
`define REG_CONTROL 2'h0
`define REG_COUNT 2'h1
`define REG_PERIOD 2'h2
`define ADDR_STATUS 12'h050
`define ADDR_TOP_LIMIT 12'h050

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTL_RUN 15
`define CTL_IDLE_STOP 13
`define CTL_GATE 6
`define CTL_PRESCALE_HI 5
`define CTL_PRESCALE_LO 4
`define CTL_JOIN 3
`define CTL_SYNC 2
`define CTL_CLOCK_SRC 1

// Writable bits per control register kind
`define CTL_MASK_BASIC 16'ha076
`define CTL_MASK_PAIR_LOW 16'ha07a
`define CTL_MASK_PAIR_HIGH 16'ha072

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CONTROL_RESET 16'h0000
`define COUNT_RESET 16'h0000
`define PERIOD_RESET 16'hffff
`define STATUS_RESET 5'h00

// ----------------------------------------
// Prescaler select codes and terminal counts
// ----------------------------------------
`define PRESCALE_CODE_DIV1 2'b00
`define PRESCALE_CODE_DIV8 2'b01
`define PRESCALE_CODE_DIV64 2'b10
`define PRESCALE_LAST_DIV8 8'h07
`define PRESCALE_LAST_DIV64 8'h3f
`define PRESCALE_LAST_DIV256 8'hff

// Event index that drives the converter trigger
`define ADC_TRIGGER_TIMER 2

`endif

/* hw/general_purpose_timer_set.v */
// Functional notes
// - Basic timer run bit starts/stops counting.
// - Idle-stop bit halts timer during Idle.
// - Gate bit accumulates only while gate high.
// - Prescale codes divide by 1/8/64/256.
// - Sync bit synchronises external clock, basic timer.
// - Control write while running clears prescaler.
// - Basic timer: timer, sync counter, async counter.
// - Basic event on period match or gate fall.
// - Basic timer can run in Idle and Sleep.
// - Join bit in low timer forms 32-bit pair.
// - Joined pair ignores high timer control bits.
// - Joined match flags the high timer event.
// - Joined count: high word upper, low lower.
// - Joined period: high word upper, low lower.
// - Joined pair matches full 32-bit period.
// - Pairable timers count synchronously only.
// - Period match drives converter trigger output.
// - Unused control bits read zero, ignore writes.
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/1ns
`include "general_purpose_timer_set_regs.vh"

module general_purpose_timer_set (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire idle_mode,
    input wire sleep_mode,
    input wire first_timer_clock_pin,
    input wire [3:0] pair_timer_clock_pin,
    output wire [4:0] timer_event,
    output wire adc_trigger
);

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------

    // The prescaler counts qualified input pulses, not raw pclk cycles, so in
    // external mode the ratio applies to the pin's own rate, in gated mode to pclk cycles with the gate high.
    // Prescaler reaches its terminal count for the selected ratio
    function pre_done;
        input [7:0] pre;
        input [1:0] sel;
        begin
            case (sel)
                `PRESCALE_CODE_DIV1: pre_done = 1'b1;
                `PRESCALE_CODE_DIV8: pre_done = (pre == `PRESCALE_LAST_DIV8);
                `PRESCALE_CODE_DIV64: pre_done = (pre == `PRESCALE_LAST_DIV64);
                default: pre_done = (pre == `PRESCALE_LAST_DIV256);
            endcase
        end
    endfunction

    // Only the low timer of a pair keeps a join bit and only the basic
    // timer keeps a sync bit; every other bit is dropped on write.
    // Writable bit mask of a control register by timer index
    function [15:0] ctl_mask;
        input integer idx;
        begin
            if (idx == 0) begin
                ctl_mask = `CTL_MASK_BASIC;
            end else if (idx == 1 || idx == 3) begin
                ctl_mask = `CTL_MASK_PAIR_LOW;
            end else begin
                ctl_mask = `CTL_MASK_PAIR_HIGH;
            end
        end
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    // Index 0 is the basic timer, 1..4 the pairable ones. In a joined pair
    // the high timer keeps its own registers, but only its count and period
    // take part; its control word is stored and read back unused.
    reg [15:0] ctrl_r [0:4];
    reg [15:0] cnt_r [0:4];
    reg [15:0] per_r [0:4];
    reg [7:0] pre_r [0:4];
    reg [4:0] flag_r;
    reg [4:0] sync1_r;
    reg [4:0] sync2_r;
    reg [4:0] sync3_r;
    reg async_prev_r;
    reg [4:0] event_r;
    reg adc_trigger_r;
    reg [31:0] prdata_r;

    wire [4:0] pins_w;
    wire join_low_w;
    wire join_high_w;
    wire [2:0] sel_timer_w;
    wire [1:0] sel_reg_w;
    wire is_status_w;
    wire mapped_w;
    wire wr_en_w;

    reg [4:0] adv_w;
    reg [4:0] tick_w;
    reg [4:0] fall_w;
    reg [4:0] slave_w;
    reg [4:0] joined_lo_w;
    reg [4:0] ev_w;
    reg [4:0] ctl_wr_w;
    reg [31:0] rd_w;
    reg [15:0] c;
    reg ext;
    reg edge_seen;
    reg gate_on;
    reg in_tick;
    reg run;

    // Each process owns its loop index; a shared one would let the
    // combinational blocks wake each other without end
    integer i;
    integer j;
    integer k;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------

    // A word is mapped when it is aligned, inside the window, and names
    // either the status word or one of the three registers of timers 0..4.
    // Anything else answers with an error, reads zero and writes nothing,
    // so a stray pointer in software cannot disturb a running timer.
    // Zero-wait slave; unmapped words answer with an error
    assign pins_w = {pair_timer_clock_pin, first_timer_clock_pin};
    assign sel_timer_w = paddr[`ADDR_TIMER_FIELD_HI:`ADDR_TIMER_FIELD_LO];
    assign sel_reg_w = paddr[`ADDR_REG_FIELD_HI:`ADDR_REG_FIELD_LO];
    assign is_status_w = (paddr == `ADDR_STATUS);
    assign mapped_w = (paddr[1:0] == 2'b00) && (paddr <= `ADDR_TOP_LIMIT)
                      && (is_status_w || (sel_timer_w < 3'h5 && sel_reg_w != 2'h3));
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped_w;
    assign wr_en_w = psel & penable & pwrite & mapped_w;
    assign prdata = prdata_r;
    assign timer_event = event_r;
    assign adc_trigger = adc_trigger_r;

    // Changing a join bit while a pair runs splits or merges the counts
    // on the next edge; software should stop the pair first.
    // Join bits live only in the low timer of each pair
    assign join_low_w = ctrl_r[1][`CTL_JOIN];
    assign join_high_w = ctrl_r[3][`CTL_JOIN];

    // ----------------------------------------
    // Read mux
    // ----------------------------------------

    // The mux is sampled in the setup cycle, so a count read returns the
    // value one cycle before the access edge; software reading a fast
    // timer should allow for that skew.
    // Unused control bits are never stored, so they read zero
    always @* begin
        rd_w = 32'h0000_0000;
        if (is_status_w) begin
            rd_w = {27'h0000000, flag_r};
        end else if (mapped_w) begin
            case (sel_reg_w)
                `REG_CONTROL: rd_w = {16'h0000, ctrl_r[sel_timer_w]};
                `REG_COUNT: rd_w = {16'h0000, cnt_r[sel_timer_w]};
                `REG_PERIOD: rd_w = {16'h0000, per_r[sel_timer_w]};
                default: rd_w = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // Clock input, gating and prescale ticks
    // ----------------------------------------

    // Idle and Sleep only qualify counting; they never touch the stored
    // count, so a timer resumes where it stopped when the mode ends.
    // Per-timer input edge, gate and run qualification
    always @* begin
        adv_w = 5'h00;
        tick_w = 5'h00;
        fall_w = 5'h00;
        slave_w = 5'h00;
        joined_lo_w = 5'h00;
        ctl_wr_w = 5'h00;
        c = 16'h0000;
        ext = 1'b0;
        edge_seen = 1'b0;
        gate_on = 1'b0;
        in_tick = 1'b0;
        run = 1'b0;
        slave_w[2] = join_low_w;
        slave_w[4] = join_high_w;
        joined_lo_w[1] = join_low_w;
        joined_lo_w[3] = join_high_w;
        for (k = 0; k < `TIMER_COUNT_OF; k = k + 1) begin
            c = ctrl_r[k];
            ext = c[`CTL_CLOCK_SRC];
            // Async path only for the basic timer; pairable ones always synchronise
            // The raw path sees glitches on the pin; that is the price of
            // counting while the system clock is stopped.
            if (k == 0 && !c[`CTL_SYNC]) begin
                edge_seen = first_timer_clock_pin & ~async_prev_r;
            end else begin
                edge_seen = sync2_r[k] & ~sync3_r[k];
            end
            // Gate mode counts pclk while the synchronised pin is high;
            // the gate fall event comes from the same history stages
            gate_on = ~ext & c[`CTL_GATE];
            if (ext) begin
                in_tick = edge_seen;
            end else if (gate_on) begin
                in_tick = sync2_r[k];
            end else begin
                in_tick = 1'b1;
            end
            // Sleep stops the system clock; only an unsynchronised basic counter survives
            run = c[`CTL_RUN]
                  & ~(idle_mode & c[`CTL_IDLE_STOP])
                  & ~(sleep_mode & ~(k == 0 && ext && !c[`CTL_SYNC]));
            // A slave high timer never advances by itself; the low pass
            // carries it as the upper half of one 32-bit count
            adv_w[k] = run & in_tick & ~slave_w[k];
            tick_w[k] = adv_w[k] & pre_done(pre_r[k], c[`CTL_PRESCALE_HI:`CTL_PRESCALE_LO]);
            fall_w[k] = run & gate_on & ~slave_w[k] & sync3_r[k] & ~sync2_r[k];
            ctl_wr_w[k] = wr_en_w && !is_status_w && sel_timer_w == k
                          && sel_reg_w == `REG_CONTROL;
        end
    end

    // ----------------------------------------
    // Events
    // ----------------------------------------

    // Joined pair reports through the high timer's event bit
    always @* begin
        ev_w = 5'h00;
        // A joined low timer compares all 32 bits and reports one bit up,
        // so the low word never pulses on its own while the pair is joined
        for (j = 0; j < `TIMER_COUNT_OF; j = j + 1) begin
            if (joined_lo_w[j]) begin
                if (tick_w[j] && {cnt_r[j+1], cnt_r[j]} == {per_r[j+1], per_r[j]}) begin
                    ev_w[j+1] = 1'b1;
                end
                if (fall_w[j]) begin
                    ev_w[j+1] = 1'b1;
                end
            end else if (!slave_w[j]) begin
                if ((tick_w[j] && cnt_r[j] == per_r[j]) || fall_w[j]) begin
                    ev_w[j] = 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // Registers and counters
    // ----------------------------------------

    // One clocked process holds every register so that the priority of
    // bus writes over hardware updates is plain from the order below.
    // Counting into a joined high word happens in the low timer's pass.
    // Bus writes come last so a count load beats the counter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < `TIMER_COUNT_OF; i = i + 1) begin
                ctrl_r[i] <= `CONTROL_RESET;
                cnt_r[i] <= `COUNT_RESET;
                per_r[i] <= `PERIOD_RESET;
                pre_r[i] <= 8'h00;
            end
            flag_r <= `STATUS_RESET;
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
            sync3_r <= 5'h00;
            async_prev_r <= 1'b0;
            event_r <= 5'h00;
            adc_trigger_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            // Pins are sampled every edge even when no timer runs, so the
            // history is valid the moment a timer is started
            // Two-stage synchroniser plus a history stage for edges
            sync1_r <= pins_w;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            async_prev_r <= first_timer_clock_pin;
            event_r <= ev_w;
            adc_trigger_r <= ev_w[`ADC_TRIGGER_TIMER];
            // Clearing by writing ones leaves other flags alone, so software
            // never loses an event it has not yet seen
            // Set beats clear when both land together
            if (wr_en_w && is_status_w) begin
                flag_r <= (flag_r & ~pwdata[4:0]) | ev_w;
            end else begin
                flag_r <= flag_r | ev_w;
            end
            // Read data captured in the setup cycle
            if (psel && !penable) begin
                prdata_r <= rd_w;
            end
            for (i = 0; i < `TIMER_COUNT_OF; i = i + 1) begin
                // The old run bit decides, so starting a stopped timer keeps
                // whatever partial prescale it had
                // Prescaler
                if (ctl_wr_w[i] && ctrl_r[i][`CTL_RUN]) begin
                    pre_r[i] <= 8'h00;
                end else if (adv_w[i]) begin
                    if (tick_w[i]) begin
                        pre_r[i] <= 8'h00;
                    end else begin
                        pre_r[i] <= pre_r[i] + 8'h01;
                    end
                end
                // Match wraps to zero on the tick after equality, so a period
                // of p gives p + 1 ticks between events
                // Counter
                if (tick_w[i]) begin
                    if (joined_lo_w[i]) begin
                        if ({cnt_r[i+1], cnt_r[i]} == {per_r[i+1], per_r[i]}) begin
                            {cnt_r[i+1], cnt_r[i]} <= 32'h0000_0000;
                        end else begin
                            {cnt_r[i+1], cnt_r[i]} <= {cnt_r[i+1], cnt_r[i]} + 32'h0000_0001;
                        end
                    end else if (cnt_r[i] == per_r[i]) begin
                        cnt_r[i] <= 16'h0000;
                    end else begin
                        cnt_r[i] <= cnt_r[i] + 16'h0001;
                    end
                end
                // A write to a high word of a joined pair lands after the
                // low pass above and therefore wins over the carry
                // Software access
                if (wr_en_w && !is_status_w && sel_timer_w == i) begin
                    case (sel_reg_w)
                        `REG_CONTROL: ctrl_r[i] <= pwdata[15:0] & ctl_mask(i);
                        `REG_COUNT: cnt_r[i] <= pwdata[15:0];
                        `REG_PERIOD: per_r[i] <= pwdata[15:0];
                        default: ;
                    endcase
                end
            end
        end
    end

endmodule // general_purpose_timer_set

/* bench/pin_clock_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// External clock and gate pin source
// ----------------------------------------
module pin_clock_model #(parameter [7:0] HALF = 8'h04) (
    input wire pclk,
    input wire run,
    output reg [4:0] pins = 5'h00
);
    reg [7:0] cnt_r = 8'h00;
    // Toggle only in bursts; parked low so no stray edge counts
    always @(posedge pclk) begin
        if (!run) begin
            cnt_r <= 8'h00;
            pins <= 5'h00;
        end else if (cnt_r == HALF - 8'h01) begin
            cnt_r <= 8'h00;
            pins <= ~pins;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
endmodule // pin_clock_model

/* bench/tset_checker.sv */
`timescale 1ns/1ns
`include "general_purpose_timer_set_regs.vh"
// ----------------------------------------
// Bus and event checks
// ----------------------------------------
module tset_checker (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire sleep_mode,
    input wire [4:0] timer_event,
    input wire adc_trigger
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Read access phase
    wire rd = psel && penable && !pwrite;
    chk_ready_high: assert property (penable |-> pready) else $error("no ready");
    chk_err_phase: assert property (pslverr |-> psel && penable) else $error("stray err");
    chk_range_err: assert property (psel && penable && paddr > 12'h050 |-> pslverr) else $error("no err");
    chk_align_err: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr) else $error("no err");
    chk_bad_zero: assert property (rd && pslverr |-> prdata == 32'h0) else $error("bad data");
    chk_upper_zero: assert property (rd |-> prdata[31:16] == 16'h0) else $error("upper set");
    chk_basic_mask: assert property (rd && paddr == 12'h000 |-> (prdata[15:0] & ~`CTL_MASK_BASIC) == 16'h0)
        else $error("ctl bits");
    chk_trig_event: assert property (adc_trigger == timer_event[2]) else $error("trigger");
    chk_sleep_quiet: assert property (sleep_mode [*3] |-> timer_event[4:1] == 4'h0) else $error("sleep ev");
    cover property (timer_event[0]);
    cover property (adc_trigger);
    cover property (pslverr);
endmodule // tset_checker

/* bench/general_purpose_timer_set_bench.sv */
`timescale 1ns/1ns
`include "general_purpose_timer_set_regs.vh"
`define CHECK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin num_errors++; \
    $display("mismatch %s exp %0h got %0h", nm, ex, got); end end
// ----------------------------------------
// Timer set bench
// ----------------------------------------
module general_purpose_timer_set_bench;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    reg idle_mode = 0, sleep_mode = 0, run = 0, e;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, q, d;
    integer num_errors = 0, comparisons = 0, seed, t, g, n;
    wire [31:0] prdata;
    wire pready, pslverr, adc_trigger;
    wire [4:0] timer_event, pins;
    // Bus clock
    initial forever #5 pclk = ~pclk;
    general_purpose_timer_set DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .idle_mode(idle_mode), .sleep_mode(sleep_mode),
        .first_timer_clock_pin(pins[0]), .pair_timer_clock_pin(pins[4:1]),
        .timer_event(timer_event), .adc_trigger(adc_trigger));
    pin_clock_model #(.HALF(8'h04)) PINS (.pclk(pclk), .run(run), .pins(pins));
    function integer div(input integer c);
        div = (c == 0) ? 1 : (c == 1) ? 8 : (c == 2) ? 64 : 256;
    endfunction
    function [15:0] msk(input integer k);
        msk = (k == 0) ? `CTL_MASK_BASIC : k[0] ? `CTL_MASK_PAIR_LOW : `CTL_MASK_PAIR_HIGH;
    endfunction
    task conclude;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // One transfer; data and error taken at the ready edge
    task apb(input integer a, input w, input [31:0] wd);
        integer i;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a[11:0];
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        if (i == 20) begin
            num_errors++;
            conclude;
        end
    endtask
    // Cycles between two pulses; a hang ends the run
    task gap(input integer k);
        integer i, s;
        s = -1;
        g = -1;
        for (i = 0; i < 3000 && g < 0; i++) begin
            @(posedge pclk);
            #1;
            if (timer_event[k] === 1'b1) begin
                if (s >= 0) g = i - s;
                s = i;
            end
        end
        if (g < 0) begin
            num_errors++;
            conclude;
        end
    endtask
    task evs(input integer k, input integer c);
        n = 0;
        repeat (c) begin
            @(posedge pclk);
            #1;
            n += (timer_event[k] === 1'b1);
        end
    endtask
    // Main sequence
    initial begin
        seed = 32'h6fef;
        repeat (6) @(posedge pclk);
        presetn <= 1;
        for (t = 0; t < 5; t++) begin
            apb(t * 16, 1'b0, 32'h0);
            `CHECK("ctl reset", 32'h0, q)
            apb(t * 16 + 8, 1'b0, 32'h0);
            `CHECK("period reset", 32'hffff, q)
            apb(t * 16, 1'b1, 32'hffff7fff);
            apb(t * 16, 1'b0, 32'h0);
            `CHECK("ctl bits", {16'h0, msk(t) & 16'h7fff}, q)
            apb(t * 16, 1'b1, 32'h0);
            d = $random(seed);
            apb(t * 16 + 4, 1'b1, d);
            apb(t * 16 + 4, 1'b0, 32'h0);
            `CHECK("count rw", {16'h0, d[15:0]}, q)
            apb(12 + t * 47, 1'b0, 32'h0);
            `CHECK("unmapped", 33'h100000000, {e, q})
        end
        for (t = 0; t < 4; t++) begin
            apb(8, 1'b1, 32'h1);
            apb(4, 1'b1, 32'h0);
            apb(0, 1'b1, 32'h8000 | (t << 4));
            gap(0);
            `CHECK("prescale gap", 2 * div(t), g)
            apb(0, 1'b1, 32'h0);
        end
        // Only the basic timer has fired so far
        apb(80, 1'b0, 32'h0);
        `CHECK("flags set", 32'h1, q)
        apb(80, 1'b1, 32'h1f);
        apb(80, 1'b0, 32'h0);
        `CHECK("flags clear", 32'h0, q)
        evs(0, 600);
        `CHECK("stopped", 0, n)
        apb(0, 1'b1, 32'ha000);
        idle_mode <= 1;
        evs(0, 40);
        `CHECK("idle stop", 0, n)
        apb(0, 1'b1, 32'h8000);
        evs(0, 40);
        `CHECK("idle run", 20, n)
        apb(0, 1'b1, 32'h0);
        idle_mode <= 0;
        apb(8, 1'b1, 32'hffff);
        apb(0, 1'b1, 32'h8040);
        run <= 1;
        evs(0, 80);
        `CHECK("gate falls", 1'b1, n > 8)
        apb(0, 1'b1, 32'h0);
        apb(4, 1'b1, 32'h0);
        apb(8, 1'b1, 32'h2);
        apb(0, 1'b1, 32'h8046);
        gap(0);
        `CHECK("sync ext gap", 24, g)
        apb(0, 1'b1, 32'h8002);
        sleep_mode <= 1;
        gap(0);
        `CHECK("async sleep gap", 24, g)
        apb(0, 1'b1, 32'h0);
        sleep_mode <= 0;
        run <= 0;
        // Pair setup, run bit last
        apb(16, 1'b1, 32'h8);
        apb(24, 1'b1, 32'h5);
        apb(40, 1'b1, 32'h0);
        apb(20, 1'b1, 32'h0);
        apb(36, 1'b1, 32'h0);
        apb(32, 1'b1, 32'ha030);
        apb(16, 1'b1, 32'h8008);
        gap(2);
        `CHECK("joined gap", 6, g)
        evs(1, 50);
        `CHECK("low word quiet", 0, n)
        apb(16, 1'b1, 32'h8);
        apb(20, 1'b1, 32'hfff0);
        apb(40, 1'b1, 32'h2);
        apb(16, 1'b1, 32'h8008);
        evs(2, 100);
        apb(16, 1'b1, 32'h8);
        apb(36, 1'b0, 32'h0);
        `CHECK("high word carry", 32'h1, q)
        `CHECK("no early match", 0, n)
        apb(16, 1'b1, 32'h0);
        apb(20, 1'b1, 32'h0);
        apb(16, 1'b1, 32'h8000);
        gap(1);
        `CHECK("split gap", 6, g)
        // Second pair joined; its match flags the high timer only
        apb(56, 1'b1, 32'h3);
        apb(72, 1'b1, 32'h0);
        apb(52, 1'b1, 32'h0);
        apb(68, 1'b1, 32'h0);
        apb(48, 1'b1, 32'h8008);
        gap(4);
        `CHECK("second pair gap", 4, g)
        evs(3, 20);
        `CHECK("second low quiet", 0, n)
        apb(80, 1'b0, 32'h0);
        `CHECK("flags seen", 32'h17, q)
        conclude;
    end
endmodule // general_purpose_timer_set_bench

bind general_purpose_timer_set tset_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_mode(sleep_mode), .timer_event(timer_event), .adc_trigger(adc_trigger));
